//--- hw/sdram_command_interface.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module sdram_command_interface #(
  parameter int unsigned DATA_W = sdram_cmd_pkg::DATA_W,
  parameter int unsigned FIFO_DEPTH = sdram_cmd_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command pins from the controller
  input wire logic clock_gate,
  input wire logic select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [sdram_cmd_pkg::BANK_W-1:0] bank_select_lines,
  input wire logic [sdram_cmd_pkg::ADDR_W-1:0] address_lines,
  input wire logic extended_temp_option,
  // write data from the controller
  input wire logic [DATA_W-1:0] wr_data,
  // array side: one access per cycle
  output logic array_en,
  output logic array_we,
  output logic [sdram_cmd_pkg::BANK_W-1:0] array_bank,
  output logic [sdram_cmd_pkg::ROW_W-1:0] array_row,
  output logic [sdram_cmd_pkg::COL_W-1:0] array_col,
  output logic [DATA_W-1:0] array_wdata,
  input wire logic [DATA_W-1:0] array_rdata,
  // read data stream through the fifo
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [DATA_W-1:0] rd_data,
  // status
  output logic [sdram_cmd_pkg::NUM_BANKS-1:0] bank_open,
  output logic [sdram_cmd_pkg::NUM_BANKS-1:0] bank_precharging,
  output logic burst_active,
  output logic [sdram_cmd_pkg::ADDR_W-1:0] burst_length_setting,
  output sdram_cmd_pkg::power_state_e power_state,
  output logic refresh_seen,
  output logic illegal_self_refresh
);
  localparam int unsigned NB = sdram_cmd_pkg::NUM_BANKS;
  localparam int unsigned BW = sdram_cmd_pkg::BANK_W;
  localparam int unsigned CW = sdram_cmd_pkg::COL_W;
  localparam int unsigned RW = sdram_cmd_pkg::ROW_W;
  localparam int unsigned AW = sdram_cmd_pkg::ADDR_W;
  localparam int unsigned PCW = 4;
  localparam logic [PCW-1:0] PRE_LOAD = PCW'(sdram_cmd_pkg::PRECHARGE_CYCLES);
  localparam int unsigned PIN_W = 5 + BW + AW + 1 + DATA_W;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [PIN_W-1:0] pins_raw; // all pins packed
  logic [PIN_W-1:0] pins_sync; // after two flops
  // idle pins: gate high, strobes high
  localparam logic [PIN_W-1:0] PIN_INIT = {5'h1f, {(PIN_W-5){1'b0}}};

  assign pins_raw = {clock_gate, select_n, row_strobe_n, col_strobe_n, write_strobe_n,
                     bank_select_lines, address_lines, extended_temp_option, wr_data};

  // every pin sampled by the rising clock
  sdram_sync2 #(.WIDTH(PIN_W), .INIT(PIN_INIT)) u_sync (
    .clk(clk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_sync)
  );

  wire s_gate = pins_sync[PIN_W-1];
  wire [3:0] s_cmd = pins_sync[PIN_W-2 -: 4];
  wire [BW-1:0] s_bank = pins_sync[PIN_W-6 -: BW];
  wire [AW-1:0] s_addr = pins_sync[PIN_W-6-BW -: AW];
  wire s_ext_temp = pins_sync[DATA_W];
  wire [DATA_W-1:0] s_wdata = pins_sync[DATA_W-1:0];

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // burst length in beats minus one from the setting field
  function automatic logic [CW-1:0] burst_last(input logic [2:0] code);
    unique case (code)
      sdram_cmd_pkg::BURST_LEN_1: burst_last = CW'(0);
      sdram_cmd_pkg::BURST_LEN_2: burst_last = CW'(1);
      sdram_cmd_pkg::BURST_LEN_4: burst_last = CW'(3);
      sdram_cmd_pkg::BURST_LEN_8: burst_last = CW'(7);
      default: burst_last = {CW{1'b1}}; // full page and unused codes
    endcase
  endfunction

  // one-hot bank decode
  function automatic logic [NB-1:0] bank_hot(input logic [BW-1:0] b);
    bank_hot = NB'(1) << b;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // command decode
  logic clk_acts; // clock gate lets this edge act
  logic [3:0] cmd; // effective command
  assign clk_acts = s_gate && (power_state == sdram_cmd_pkg::PWR_RUN);
  // select high turns every command into a no-op
  assign cmd = s_cmd[3] ? sdram_cmd_pkg::CMD_NOP : s_cmd;

  wire is_act = clk_acts && (cmd == sdram_cmd_pkg::CMD_ACTIVATE);
  wire is_rd = clk_acts && (cmd == sdram_cmd_pkg::CMD_READ);
  wire is_wr = clk_acts && (cmd == sdram_cmd_pkg::CMD_WRITE);
  wire is_col = is_rd || is_wr;
  wire is_term = clk_acts && (cmd == sdram_cmd_pkg::CMD_TERMINATE);
  wire is_pre = clk_acts && (cmd == sdram_cmd_pkg::CMD_PRECHARGE);
  wire is_ref = clk_acts && (cmd == sdram_cmd_pkg::CMD_REFRESH);
  wire is_lmr = clk_acts && (cmd == sdram_cmd_pkg::CMD_LOAD_MODE);
  wire a10 = s_addr[sdram_cmd_pkg::PRECHARGE_FLAG_BIT];
  wire [NB-1:0] cmd_bank_hot = bank_hot(s_bank);
  // line ten high on precharge targets every bank
  wire [NB-1:0] pre_mask = a10 ? {NB{1'b1}} : cmd_bank_hot;

  //////////////////////////////////////////////////////////////////////////////
  // configuration register
  // load mode copies address lines into the setting word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) burst_length_setting <= sdram_cmd_pkg::MODE_RESET;
    else if (is_lmr) burst_length_setting <= s_addr;
  end
  wire [2:0] bl_code =
    burst_length_setting[sdram_cmd_pkg::BURST_FIELD_LSB +: sdram_cmd_pkg::BURST_FIELD_W];

  //////////////////////////////////////////////////////////////////////////////
  // per-bank row state
  logic [RW-1:0] open_row [NB]; // latched row per bank
  logic [PCW-1:0] pre_cnt [NB]; // precharge timers
  logic [NB-1:0] burst_end_hot; // bank closed by auto precharge this cycle

  // activate, precharge and self-timed precharge for each bank
  for (genvar b = 0; b < NB; b++) begin : g_bank
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        open_row[b] <= '0;
        bank_open[b] <= 1'b0;
        pre_cnt[b] <= '0;
      end else if (is_act && cmd_bank_hot[b]) begin
        open_row[b] <= s_addr[RW-1:0];
        bank_open[b] <= 1'b1;
      end else if ((is_pre && pre_mask[b]) || burst_end_hot[b]) begin
        // other banks keep working meanwhile
        bank_open[b] <= 1'b0;
        pre_cnt[b] <= PRE_LOAD;
      end else if (pre_cnt[b] != '0) begin
        pre_cnt[b] <= pre_cnt[b] - 1'b1;
      end
    end
    assign bank_precharging[b] = (pre_cnt[b] != '0);
  end

  //////////////////////////////////////////////////////////////////////////////
  // burst engine
  logic [BW-1:0] burst_bank; // bank of current burst
  logic [CW-1:0] burst_col; // current column
  logic [CW-1:0] beats_left; // beats remaining minus one
  logic burst_write; // direction
  logic burst_ap; // auto precharge asked
  logic advancing; // burst continues this edge
  logic burst_done; // final beat on this edge

  assign advancing = burst_active && clk_acts && !is_col && !is_term;
  assign burst_done = advancing && (beats_left == '0);
  // single-beat column command with auto precharge
  logic ap_single; // close right after one beat
  assign ap_single = is_col && a10 && (burst_last(bl_code) == '0);
  // a one-beat burst has no advancing edge, so it closes on its own command
  assign burst_end_hot = ((burst_done && burst_ap) ? bank_hot(burst_bank) : '0)
                       | (ap_single ? cmd_bank_hot : '0);

  // a column command restarts and terminate stops; each other edge the clock gate lets act advances the counter until the last beat
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burst_active <= 1'b0;
      burst_bank <= '0;
      burst_col <= '0;
      beats_left <= '0;
      burst_write <= 1'b0;
      burst_ap <= 1'b0;
    end else if (is_col) begin
      burst_active <= (burst_last(bl_code) != '0);
      burst_bank <= s_bank;
      burst_col <= s_addr[CW-1:0] + 1'b1;
      beats_left <= burst_last(bl_code) - 1'b1;
      burst_write <= is_wr;
      burst_ap <= a10;
    end else if (is_term || burst_done) begin
      burst_active <= 1'b0;
    end else if (advancing) begin
      burst_col <= burst_col + 1'b1;
      beats_left <= beats_left - 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // array access
  logic fifo_ready; // read path can take a word
  wire access_now = is_col || advancing;
  wire access_wr = is_col ? is_wr : burst_write;
  wire [BW-1:0] access_bank = is_col ? s_bank : burst_bank;
  wire [CW-1:0] access_col = is_col ? s_addr[CW-1:0] : burst_col;

  // array strobes are registered
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      array_en <= 1'b0;
      array_we <= 1'b0;
      array_bank <= '0;
      array_row <= '0;
      array_col <= '0;
      array_wdata <= '0;
    end else begin
      array_en <= access_now && (access_wr || fifo_ready);
      array_we <= access_now && access_wr;
      array_bank <= access_bank;
      array_row <= open_row[access_bank];
      array_col <= access_col;
      array_wdata <= s_wdata;
    end
  end
  logic rd_pending; // read beat returns next cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) rd_pending <= 1'b0;
    else rd_pending <= array_en && !array_we;
  end

  // read data buffered toward the controller
  sdram_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rd_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(rd_pending),
    .in_ready(fifo_ready),
    .in_data(array_rdata),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // power states
  logic is_ref_entry; // refresh code on the synchronised pins; the gate is tested where it is used
  assign is_ref_entry = !s_cmd[3] && (s_cmd == sdram_cmd_pkg::CMD_REFRESH);
  // gate low picks state from bank status; gate high returns
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_state <= sdram_cmd_pkg::PWR_RUN;
      refresh_seen <= 1'b0;
      illegal_self_refresh <= 1'b0;
    end else begin
      refresh_seen <= is_ref;
      illegal_self_refresh <= illegal_self_refresh || (!s_gate && is_ref_entry && s_ext_temp);
      unique case (power_state)
        sdram_cmd_pkg::PWR_RUN: begin
          if (!s_gate) begin
            if (burst_active) power_state <= sdram_cmd_pkg::PWR_SUSPEND;
            else if (bank_open != '0) power_state <= sdram_cmd_pkg::PWR_ACTIVE_DOWN;
            else if (is_ref_entry && !s_ext_temp) power_state <= sdram_cmd_pkg::PWR_SELF_REFRESH;
            else power_state <= sdram_cmd_pkg::PWR_IDLE_DOWN;
          end
        end
        sdram_cmd_pkg::PWR_SUSPEND: begin
          if (s_gate) power_state <= sdram_cmd_pkg::PWR_RUN;
        end
        default: begin
          // other pins ignored; only the gate is watched
          if (s_gate) power_state <= sdram_cmd_pkg::PWR_RUN;
        end
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_select_masks;
    @(posedge clk) disable iff (rst) s_cmd[3] |-> !is_act && !is_col && !is_pre;
  endproperty
  a_select_masks: assert property (p_select_masks) else $error("command not masked");

  property p_activate_opens;
    @(posedge clk) disable iff (rst) is_act |=> bank_open[$past(s_bank)];
  endproperty
  a_activate_opens: assert property (p_activate_opens) else $error("bank not opened");

  property p_precharge_closes;
    @(posedge clk) disable iff (rst) (is_pre && a10) |=> bank_open == '0;
  endproperty
  a_precharge_closes: assert property (p_precharge_closes) else $error("all-bank close");

  property p_col_step;
    @(posedge clk) disable iff (rst) advancing |=> array_col == $past(burst_col);
  endproperty
  a_col_step: assert property (p_col_step) else $error("burst column wrong");

  property p_col_first;
    @(posedge clk) disable iff (rst) is_col |=> array_col == $past(s_addr[CW-1:0]);
  endproperty
  a_col_first: assert property (p_col_first) else $error("first column wrong");

  property p_gate_holds;
    @(posedge clk) disable iff (rst)
      (power_state == sdram_cmd_pkg::PWR_RUN && !s_gate) |=> power_state != sdram_cmd_pkg::PWR_RUN;
  endproperty
  a_gate_holds: assert property (p_gate_holds) else $error("gate low ignored");

  property p_lmr_load;
    @(posedge clk) disable iff (rst) is_lmr |=> burst_length_setting == $past(s_addr);
  endproperty
  a_lmr_load: assert property (p_lmr_load) else $error("mode not loaded");

  property p_term_stops;
    @(posedge clk) disable iff (rst) (is_term && burst_active) |=> !burst_active;
  endproperty
  a_term_stops: assert property (p_term_stops) else $error("terminate ignored");
endmodule

//--- hw/sdram_cmd_pkg.sv
package sdram_cmd_pkg;
  // array geometry
  localparam int unsigned NUM_BANKS = 4;
  localparam int unsigned BANK_W = 2;
  localparam int unsigned ROW_W = 12;
  localparam int unsigned COL_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned ADDR_W = 12;
  // address line ten: auto precharge on column commands, all-banks on precharge
  localparam int unsigned PRECHARGE_FLAG_BIT = 10;
  // configuration word fields taken from the address lines
  localparam int unsigned BURST_FIELD_LSB = 0;
  localparam int unsigned BURST_FIELD_W = 3;
  localparam logic [2:0] BURST_LEN_1 = 3'h0;
  localparam logic [2:0] BURST_LEN_2 = 3'h1;
  localparam logic [2:0] BURST_LEN_4 = 3'h2;
  localparam logic [2:0] BURST_LEN_8 = 3'h3;
  localparam logic [2:0] BURST_LEN_PAGE = 3'h7;
  localparam logic [ADDR_W-1:0] MODE_RESET = 12'h000;
  // self-timed precharge duration
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned PRECHARGE_NS = 20;
  localparam int unsigned PRECHARGE_CYCLES = (PRECHARGE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FIFO_DEPTH = 8;
  // command code {select_n, row_strobe_n, col_strobe_n, write_strobe_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACTIVATE = 4'h3;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_TERMINATE = 4'h6;
  localparam logic [3:0] CMD_PRECHARGE = 4'h2;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE = 4'h0;
  // power state of the device
  typedef enum logic [4:0] {
    PWR_RUN = 5'h01,
    PWR_IDLE_DOWN = 5'h02,
    PWR_SELF_REFRESH = 5'h04,
    PWR_ACTIVE_DOWN = 5'h08,
    PWR_SUSPEND = 5'h10
  } power_state_e;
endpackage

//--- hw/sdram_sync2.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin inputs
module sdram_sync2 #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // level in and out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta; // first stage, read only by q

  // two stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

//--- hw/sdram_fifo.sv
`timescale 1ns/1ps
// flop-based fifo with valid/ready on both sides
module sdram_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [PW-1:0] wr_ptr; // write index
  logic [PW-1:0] rd_ptr; // read index
  logic [PW:0] count; // occupancy
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  // full compare at count width, so a depth of a power of two does not wrap to zero
  assign in_ready = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  // pointer and count update
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule

//--- test/sdram_ctrl_model.sv
`timescale 1ns/1ps
// controller stand-in: drives the command pins, one command per clock
module sdram_ctrl_model (
  // clock
  input wire logic clk,
  // command pins toward the memory
  output logic clock_gate,
  output logic select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_strobe_n,
  output logic [1:0] bank_select_lines,
  output logic [11:0] address_lines
);
  ////////////////////////////////////////////////////////////////////////////////
  // idle pins at time zero: no command, gate held high
  initial begin
    clock_gate = 1'b1;
    {select_n, row_strobe_n, col_strobe_n, write_strobe_n} = sdram_cmd_pkg::CMD_NOP;
    bank_select_lines = 2'h0;
    address_lines = 12'h000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one command on the next edge, coded by the four strobe levels
  task automatic issue(input logic [3:0] cmd, input logic [1:0] bank, input logic [11:0] addr);
    @(posedge clk);
    {select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= cmd;
    bank_select_lines <= bank;
    address_lines <= addr;
  endtask
  // back to idle; stale address is inverted so nothing leans on it
  task automatic nop();
    @(posedge clk);
    {select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= sdram_cmd_pkg::CMD_NOP;
    bank_select_lines <= ~bank_select_lines;
    address_lines <= ~address_lines;
  endtask
  // clock gate level, changed on an edge
  task automatic gate(input logic g);
    @(posedge clk);
    clock_gate <= g;
  endtask
  // refresh code with the gate dropped on the same edge
  task automatic self_refresh();
    @(posedge clk);
    {select_n, row_strobe_n, col_strobe_n, write_strobe_n} <= sdram_cmd_pkg::CMD_REFRESH;
    clock_gate <= 1'b0;
  endtask
endmodule

//--- test/sdram_command_interface_tb.sv
`timescale 1ns/1ps
// bench: controller model on the pins, array stand-in behind the block
module sdram_command_interface_tb;
  // row kept open in bank two
  localparam logic [11:0] ROW = 12'h5a3;
  // clock, reset and loose inputs
  logic clk, rst, extended_temp_option, rd_ready;
  logic [31:0] wr_data, array_rdata, array_wdata, rd_data;
  // pins from the controller model
  logic clock_gate, select_n, row_strobe_n, col_strobe_n, write_strobe_n;
  logic [1:0] bank_select_lines, array_bank;
  logic [11:0] address_lines, array_row, burst_length_setting;
  // block outputs
  logic array_en, array_we, rd_valid, burst_active, refresh_seen, illegal_self_refresh;
  logic [7:0] array_col;
  logic [3:0] bank_open, bank_precharging;
  sdram_cmd_pkg::power_state_e power_state;
  // bookkeeping
  int num_errors, compares, beat_cnt, b0, k;
  logic [7:0] cols[$];

  // clock
  always #4 clk = ~clk;

  sdram_ctrl_model ctrl (.clk(clk), .clock_gate(clock_gate), .select_n(select_n),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select_lines(bank_select_lines),
    .address_lines(address_lines));

  sdram_command_interface dut (.clk(clk), .rst(rst), .clock_gate(clock_gate),
    .select_n(select_n), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .write_strobe_n(write_strobe_n), .bank_select_lines(bank_select_lines),
    .address_lines(address_lines), .extended_temp_option(extended_temp_option),
    .wr_data(wr_data), .array_en(array_en), .array_we(array_we), .array_bank(array_bank),
    .array_row(array_row), .array_col(array_col), .array_wdata(array_wdata),
    .array_rdata(array_rdata), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .bank_open(bank_open), .bank_precharging(bank_precharging),
    .burst_active(burst_active), .burst_length_setting(burst_length_setting),
    .power_state(power_state), .refresh_seen(refresh_seen),
    .illegal_self_refresh(illegal_self_refresh));

  ////////////////////////////////////////////////////////////////////////////////
  // array stand-in: read word carries its own address, inverted otherwise
  always @(posedge clk) begin
    if (array_en === 1'b1 && array_we === 1'b0) begin
      array_rdata <= {10'h0, array_bank, array_row, array_col};
    end else begin
      array_rdata <= ~array_rdata;
    end
  end
  // running count of array beats
  always @(posedge clk) begin
    if (array_en === 1'b1) begin
      beat_cnt <= beat_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // status probe by selector
  function automatic logic [31:0] probe(input int sel);
    case (sel)
      0: return {27'h0, power_state};
      1: return {28'h0, bank_open};
      2: return {28'h0, bank_precharging};
      default: return {31'h0, refresh_seen};
    endcase
  endfunction
  // bounded wait for a status value; a miss ends the run
  task automatic wait_for(input int sel, input logic [31:0] exp);
    int t;
    t = 0;
    while (probe(sel) !== exp && t < 40) begin
      @(posedge clk);
      t++;
    end
    chk(probe(sel), exp);
    if (probe(sel) !== exp) test_done();
  endtask
  // record array beats over a window and check their address and data
  task automatic collect(input int n, input logic we, input logic [1:0] b, input logic [11:0] r);
    cols = {};
    repeat (n) begin
      @(posedge clk);
      if (array_en === 1'b1) begin
        cols.push_back(array_col);
        chk({31'h0, array_we}, {31'h0, we});
        chk({30'h0, array_bank}, {30'h0, b});
        chk({20'h0, array_row}, {20'h0, r});
        if (we) chk(array_wdata, wr_data);
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // reset values, then open the working row
  task automatic t_reset();
    chk(probe(0), {27'h0, sdram_cmd_pkg::PWR_RUN});
    chk(probe(1), 32'h0);
    chk({31'h0, rd_valid}, 32'h0);
    chk({20'h0, burst_length_setting}, {20'h0, sdram_cmd_pkg::MODE_RESET});
    ctrl.issue(sdram_cmd_pkg::CMD_ACTIVATE, 2'h2, ROW);
    ctrl.nop();
    wait_for(1, 32'h4);
  endtask
  // the four fixed length codes (1, 2, 4, 8 beats), starting near the top so the column wraps
  task automatic t_lengths();
    for (int i = 0; i < 4; i++) begin
      wr_data <= 32'h1234abcd ^ 32'(i);
      ctrl.issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'(i));
      ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h0fe);
      ctrl.nop();
      collect(16, 1'b1, 2'h2, ROW);
      chk(32'(cols.size()), 32'h1 << i);
      foreach (cols[j]) chk({24'h0, cols[j]}, {24'h0, 8'hfe + 8'(j)});
      chk({20'h0, burst_length_setting}, 32'(i));
    end
  endtask
  // column commands on consecutive cycles restart the burst
  task automatic t_b2b();
    ctrl.issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'h002);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h020);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h080);
    ctrl.nop();
    collect(16, 1'b1, 2'h2, ROW);
    chk(32'(cols.size()), 32'h5);
    chk({24'h0, cols[0]}, 32'h20);
    chk({24'h0, cols[1]}, 32'h80);
    chk({24'h0, cols[4]}, 32'h83);
  endtask
  // page burst cut short by terminate
  task automatic t_term();
    b0 = beat_cnt;
    ctrl.issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'h007);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h000);
    repeat (3) ctrl.nop();
    ctrl.issue(sdram_cmd_pkg::CMD_TERMINATE, 2'h2, 12'h000);
    ctrl.nop();
    repeat (30) @(posedge clk);
    chk(32'(beat_cnt - b0 > 1 && beat_cnt - b0 < 12), 32'h1);
    chk({31'h0, burst_active}, 32'h0);
  endtask
  // deselected commands are masked while the burst runs on
  task automatic t_mask();
    ctrl.issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'h003);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h2, 12'h040);
    ctrl.issue(4'hb, 2'h1, 12'h111);
    ctrl.issue(4'hc, 2'h2, 12'h0a0);
    ctrl.nop();
    collect(16, 1'b1, 2'h2, ROW);
    chk(32'(cols.size()), 32'h8);
    chk({24'h0, cols[7]}, 32'h47);
    chk(probe(1), 32'h4);
  endtask
  // reads fill the buffer while the reader stalls, then drain in order
  task automatic t_fifo();
    ctrl.issue(sdram_cmd_pkg::CMD_READ, 2'h2, 12'h010);
    ctrl.nop();
    repeat (16) @(posedge clk);
    ctrl.issue(sdram_cmd_pkg::CMD_READ, 2'h2, 12'h030);
    ctrl.nop();
    repeat (16) @(posedge clk);
    chk({31'h0, rd_valid}, 32'h1);
    rd_ready <= 1'b1;
    k = 0;
    for (int t = 0; t < 40 && k < 8; t++) begin
      @(posedge clk);
      if (rd_valid === 1'b1) begin
        chk(rd_data, {10'h0, 2'h2, ROW, 8'h10 + 8'(k)});
        k++;
      end
    end
    chk(32'(k), 32'h8);
    repeat (40) @(posedge clk);
    chk({31'h0, rd_valid}, 32'h0);
  endtask
  // auto precharge on one bank while another stays open, then explicit precharges
  task automatic t_precharge();
    ctrl.issue(sdram_cmd_pkg::CMD_ACTIVATE, 2'h1, 12'h0f0);
    ctrl.nop();
    wait_for(1, 32'h6);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h1, 12'h400);
    ctrl.nop();
    wait_for(2, 32'h2);
    wait_for(1, 32'h4);
    ctrl.issue(sdram_cmd_pkg::CMD_ACTIVATE, 2'h0, 12'h001);
    ctrl.issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h2, 12'h000);
    ctrl.nop();
    wait_for(1, 32'h1);
    ctrl.issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h3, 12'h400);
    ctrl.nop();
    wait_for(1, 32'h0);
  endtask
  // gate low with banks idle, with a row open and inside a burst
  task automatic t_power();
    ctrl.gate(1'b0);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_IDLE_DOWN});
    ctrl.issue(sdram_cmd_pkg::CMD_ACTIVATE, 2'h3, 12'h003);
    ctrl.nop();
    ctrl.gate(1'b1);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_RUN});
    repeat (4) @(posedge clk);
    chk(probe(1), 32'h0);
    ctrl.issue(sdram_cmd_pkg::CMD_ACTIVATE, 2'h3, 12'h003);
    ctrl.nop();
    wait_for(1, 32'h8);
    ctrl.gate(1'b0);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_ACTIVE_DOWN});
    ctrl.gate(1'b1);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_RUN});
    ctrl.issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'h007);
    ctrl.issue(sdram_cmd_pkg::CMD_WRITE, 2'h3, 12'h000);
    ctrl.nop();
    ctrl.gate(1'b0);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_SUSPEND});
    b0 = beat_cnt;
    repeat (6) @(posedge clk);
    chk(32'(beat_cnt - b0), 32'h0);
    ctrl.gate(1'b1);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_RUN});
    ctrl.issue(sdram_cmd_pkg::CMD_TERMINATE, 2'h3, 12'h000);
    ctrl.issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
    ctrl.nop();
    wait_for(1, 32'h0);
  endtask
  // refresh, self refresh, and self refresh refused with the temperature option
  task automatic t_refresh();
    ctrl.issue(sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'h000);
    ctrl.nop();
    wait_for(3, 32'h1);
    ctrl.self_refresh();
    ctrl.nop();
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_SELF_REFRESH});
    ctrl.gate(1'b1);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_RUN});
    extended_temp_option <= 1'b1;
    ctrl.self_refresh();
    ctrl.nop();
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_IDLE_DOWN});
    chk({31'h0, illegal_self_refresh}, 32'h1);
    ctrl.gate(1'b1);
    wait_for(0, {27'h0, sdram_cmd_pkg::PWR_RUN});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    extended_temp_option = 1'b0;
    rd_ready = 1'b0;
    wr_data = 32'h1234abcd;
    array_rdata = 32'h0;
    num_errors = 0;
    compares = 0;
    beat_cnt = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_lengths();
    t_b2b();
    t_term();
    t_mask();
    t_fifo();
    t_precharge();
    t_power();
    t_refresh();
    test_done();
  end
  // watchdog against a hang
  initial begin
    #400000;
    num_errors++;
    test_done();
  end
endmodule
